// ==== core/acr_top.sv ====
`timescale 1ns/1ps
module acr_top
	import acr_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary value
	parameter int SLEEP_WAKE = SLEEP_WAKE_CYC,
	parameter int SHUT_WAKE = SHUTDOWN_WAKE_CYC
)
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic sleep_or_addr_select_pin_i,
	input wire logic [FAULT_STAT_W-1:0] fault_status_i,
	output logic [CLIP_W-1:0] clip_threshold_level_o,
	output logic amp_sleep_request_o,
	output logic amp_shutdown_n_o,
	output acr_audio_cfg_t audio_cfg_o,
	output acr_pwr_out_t pwr_o
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		acr_i2c_st_t st;
		logic scl_q;
		logic sda_q;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic addr_lsb;
		logic addr_taken;
		logic sda_oe;
		logic sda_lvl;
		logic [NUM_REGS-1:0][7:0] regs;
	} acr_top_st_t;

	acr_top_st_t q;
	acr_top_st_t next_q;
	logic wr_now;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// ************************************************************
	// Register decode
	// ************************************************************
	function automatic logic [7:0] reg_rst(input logic [7:0] idx);
		case (idx)
			REG_ID: reg_rst = DEVICE_ID;
			REG_PWR: reg_rst = RST_PWR;
			REG_DIG: reg_rst = RST_DIG;
			REG_VOL_CFG: reg_rst = RST_VOL_CFG;
			REG_LVOL: reg_rst = RST_VOL;
			REG_RVOL: reg_rst = RST_VOL;
			REG_ANA: reg_rst = RST_ANA;
			REG_FAULT: reg_rst = RST_FAULT;
			REG_CLIP_MID: reg_rst = RST_CLIP_MID;
			REG_CLIP_LOW: reg_rst = RST_CLIP_LOW;
			default: reg_rst = 8'h00;
		endcase
	endfunction : reg_rst

	function automatic logic [7:0] wr_mask(input logic [7:0] idx);
		case (idx)
			REG_PWR: wr_mask = WM_FULL;
			REG_DIG: wr_mask = WM_DIG;
			REG_VOL_CFG: wr_mask = WM_VOL_CFG;
			REG_LVOL: wr_mask = WM_FULL;
			REG_RVOL: wr_mask = WM_FULL;
			REG_ANA: wr_mask = WM_ANA;
			REG_FAULT: wr_mask = WM_FAULT;
			REG_CLIP_MID: wr_mask = WM_FULL;
			REG_CLIP_LOW: wr_mask = WM_CLIP_LOW;
			default: wr_mask = 8'h00;
		endcase
	endfunction : wr_mask

	function automatic logic [NUM_REGS-1:0][7:0] regs_rst();
		logic [NUM_REGS-1:0][7:0] r;
		r = '0;
		for (int i = 0; i < NUM_REGS; i++)
			r[i] = reg_rst(8'(i));
		return r;
	endfunction : regs_rst

	function automatic logic [7:0] rd_byte(
		input logic [7:0] idx,
		input logic [NUM_REGS-1:0][7:0] regs,
		input logic [FAULT_STAT_W-1:0] stat
	);
		if (idx == REG_FAULT)
			rd_byte = {regs[REG_FAULT][7:FAULT_STAT_W], stat};
		else if (idx < 8'(NUM_REGS))
			rd_byte = regs[idx[4:0]];
		else
			rd_byte = 8'h00;
	endfunction : rd_byte

	// ************************************************************
	// Serial control port
	// ************************************************************
	// Pins are synchronous; one stage of history gives edges
	assign scl_rise = scl_i && !q.scl_q;
	assign scl_fall = !scl_i && q.scl_q;
	assign start_seen = scl_i && q.scl_q && q.sda_q && !sda_i;
	assign stop_seen = scl_i && q.scl_q && !q.sda_q && sda_i;

	always_comb
	begin
		logic [7:0] tx;
		logic [7:0] m;
		tx = rd_byte(q.ptr, q.regs, fault_status_i);
		m = wr_mask(q.ptr);
		next_q = q;
		wr_now = 1'b0;
		next_q.scl_q = scl_i;
		next_q.sda_q = sda_i;
		if (!q.addr_taken)
		begin
			// Caught once after reset, then held
			next_q.addr_taken = 1'b1;
			next_q.addr_lsb = sleep_or_addr_select_pin_i;
		end
		if (start_seen)
		begin
			// Repeated start lands here too
			next_q.st = ACR_DEV;
			next_q.cnt = 4'h0;
			next_q.sda_oe = 1'b0;
		end
		else if (stop_seen)
		begin
			next_q.st = ACR_IDLE;
			next_q.sda_oe = 1'b0;
		end
		else
		begin
			case (q.st)
				ACR_DEV, ACR_REG, ACR_WR:
				begin
					if (scl_rise && q.cnt != 4'h8)
					begin
						next_q.shreg = {q.shreg[6:0], sda_i};
						next_q.cnt = q.cnt + 4'h1;
					end
					else if (scl_fall && q.cnt == 4'h8)
					begin
						next_q.sda_oe = 1'b1;
						if (q.st == ACR_DEV)
						begin
							if (q.addr_taken &&
								q.shreg[7:1] == {DEV_ADDR_BASE, q.addr_lsb})
								next_q.st = ACR_DEV_ACK;
							else
							begin
								next_q.st = ACR_WAIT;
								next_q.sda_oe = 1'b0;
							end
						end
						else if (q.st == ACR_REG)
						begin
							next_q.ptr = q.shreg;
							next_q.st = ACR_REG_ACK;
						end
						else
						begin
							if (q.ptr < 8'(NUM_REGS))
							begin
								wr_now = 1'b1;
								next_q.regs[q.ptr[4:0]] =
									(q.shreg & m) | (q.regs[q.ptr[4:0]] & ~m);
							end
							next_q.ptr = q.ptr + 8'h01;
							next_q.st = ACR_WR_ACK;
						end
					end
				end
				ACR_DEV_ACK, ACR_REG_ACK, ACR_WR_ACK:
				begin
					if (scl_fall)
					begin
						next_q.cnt = 4'h0;
						next_q.sda_oe = 1'b0;
						if (q.st == ACR_DEV_ACK && q.shreg[0])
						begin
							// First bit goes out as the ack clock ends
							next_q.st = ACR_RD;
							next_q.shreg = {tx[6:0], 1'b0};
							next_q.sda_oe = !tx[7];
							next_q.cnt = 4'h1;
						end
						else if (q.st == ACR_DEV_ACK)
							next_q.st = ACR_REG;
						else
							next_q.st = ACR_WR;
					end
				end
				ACR_RD:
				begin
					if (scl_fall)
					begin
						if (q.cnt == 4'h8)
						begin
							next_q.sda_oe = 1'b0;
							next_q.st = ACR_RD_ACK;
						end
						else
						begin
							next_q.sda_oe = !q.shreg[7];
							next_q.shreg = {q.shreg[6:0], 1'b0};
							next_q.cnt = q.cnt + 4'h1;
						end
					end
				end
				ACR_RD_ACK:
				begin
					if (scl_rise)
					begin
						if (sda_i)
							next_q.st = ACR_WAIT;
						else
							next_q.ptr = q.ptr + 8'h01;
					end
					else if (scl_fall)
					begin
						next_q.st = ACR_RD;
						next_q.shreg = {tx[6:0], 1'b0};
						next_q.sda_oe = !tx[7];
						next_q.cnt = 4'h1;
					end
				end
				ACR_IDLE, ACR_WAIT:
					next_q.sda_oe = 1'b0;
				default:
				begin
					next_q.st = ACR_IDLE;
					next_q.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.st <= ACR_IDLE;
			q.scl_q <= 1'b1;
			q.sda_q <= 1'b1;
			q.regs <= regs_rst();
		end
		else
			q <= next_q;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign sda_o = q.sda_lvl;
	assign sda_oe_o = q.sda_oe;
	assign clip_threshold_level_o = {q.regs[REG_PWR][7:2],
		q.regs[REG_CLIP_MID], q.regs[REG_CLIP_LOW][7:2]};
	assign amp_sleep_request_o = q.regs[REG_PWR][PWR_SLEEP_BIT];
	assign amp_shutdown_n_o = q.regs[REG_PWR][PWR_SD_BIT];
	assign audio_cfg_o = '{
		digital_path_control: q.regs[REG_DIG],
		volume_configuration: q.regs[REG_VOL_CFG],
		left_volume: q.regs[REG_LVOL],
		right_volume: q.regs[REG_RVOL],
		analog_control: q.regs[REG_ANA],
		fault_config: q.regs[REG_FAULT]
	};

	acr_power_seq #(
		.SLEEP_WAKE(SLEEP_WAKE),
		.SHUT_WAKE(SHUT_WAKE),
		.CW(12)
	) u_power_seq (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.amp_sleep_request_i(q.regs[REG_PWR][PWR_SLEEP_BIT]),
		.amp_shutdown_n_i(q.regs[REG_PWR][PWR_SD_BIT]),
		.pwr_o(pwr_o)
	);

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	id_const_a: assert property (q.regs[REG_ID] == DEVICE_ID)
		else $error("identity register changed");

	reset_pwr_a: assert property ($past(rst_i) |->
		amp_shutdown_n_o && !amp_sleep_request_o &&
		clip_threshold_level_o == 20'hFFFFF)
		else $error("power control reset value wrong");

	clip_low_wr_a: assert property (wr_now && q.ptr == REG_CLIP_LOW |=>
		clip_threshold_level_o[5:0] == $past(q.shreg[7:2]))
		else $error("clip low field not joined correctly");

	clip_high_wr_a: assert property (wr_now && q.ptr == REG_PWR |=>
		clip_threshold_level_o[19:14] == $past(q.shreg[7:2]) &&
		amp_shutdown_n_o == $past(q.shreg[0]))
		else $error("power control write not applied");

	rsvd_zero_a: assert property (q.regs[REG_RSVD7] == 8'h00 &&
		!q.regs[REG_DIG][6] && q.regs[REG_VOL_CFG][6:2] == 5'h00 &&
		q.regs[9] == 8'h00)
		else $error("reserved bits not zero");

	addr_match_a: assert property (q.st == ACR_DEV_ACK |->
		q.shreg[7:1] == {DEV_ADDR_BASE, q.addr_lsb})
		else $error("acked a foreign address");

	addr_hold_a: assert property (q.addr_taken |=>
		$stable(q.addr_lsb))
		else $error("latched address bit moved");

	ack_drive_a: assert property ((q.st == ACR_DEV_ACK ||
		q.st == ACR_REG_ACK || q.st == ACR_WR_ACK) |->
		sda_oe_o && !sda_o)
		else $error("ack not driven low");

	rd_release_a: assert property (q.st == ACR_RD_ACK && scl_rise &&
		sda_i |-> !sda_oe_o ##1 q.st == ACR_WAIT && !sda_oe_o)
		else $error("read nack not honoured");

endmodule : acr_top

// ==== common/acr_pkg.sv ====
// ****************************************************************
// Constants and types of the amplifier control register bank
// ****************************************************************
package acr_pkg;

	// ************************************************************
	// Clock and power sequencing times
	// ************************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int SLEEP_WAKE_NS = 2000;
	localparam int SHUTDOWN_WAKE_NS = 20000;
	// Least times, so round up
	localparam int SLEEP_WAKE_CYC =
		(SLEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHUTDOWN_WAKE_CYC =
		(SHUTDOWN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Slave address
	// ************************************************************
	localparam logic [5:0] DEV_ADDR_BASE = 6'h36;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam int NUM_REGS = 18;
	localparam logic [7:0] REG_ID = 8'h00;
	localparam logic [7:0] REG_PWR = 8'h01;
	localparam logic [7:0] REG_DIG = 8'h02;
	localparam logic [7:0] REG_VOL_CFG = 8'h03;
	localparam logic [7:0] REG_LVOL = 8'h04;
	localparam logic [7:0] REG_RVOL = 8'h05;
	localparam logic [7:0] REG_ANA = 8'h06;
	localparam logic [7:0] REG_RSVD7 = 8'h07;
	localparam logic [7:0] REG_FAULT = 8'h08;
	localparam logic [7:0] REG_CLIP_MID = 8'h10;
	localparam logic [7:0] REG_CLIP_LOW = 8'h11;

	// ************************************************************
	// Reset values and writable bit masks
	// ************************************************************
	localparam logic [7:0] RST_PWR = 8'hFD;
	localparam logic [7:0] RST_DIG = 8'h14;
	localparam logic [7:0] RST_VOL_CFG = 8'h80;
	localparam logic [7:0] RST_VOL = 8'hCF;
	localparam logic [7:0] RST_ANA = 8'h51;
	localparam logic [7:0] RST_FAULT = 8'h00;
	localparam logic [7:0] RST_CLIP_MID = 8'hFF;
	localparam logic [7:0] RST_CLIP_LOW = 8'hFC;
	localparam logic [7:0] WM_FULL = 8'hFF;
	localparam logic [7:0] WM_DIG = 8'hBF;
	localparam logic [7:0] WM_VOL_CFG = 8'h83;
	localparam logic [7:0] WM_ANA = 8'hFE;
	localparam logic [7:0] WM_FAULT = 8'h38;
	localparam logic [7:0] WM_CLIP_LOW = 8'hFC;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PWR_SD_BIT = 0;
	localparam int PWR_SLEEP_BIT = 1;
	localparam int FAULT_STAT_W = 3;
	localparam int CLIP_W = 20;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		ACR_IDLE = 4'h0,
		ACR_DEV = 4'h1,
		ACR_DEV_ACK = 4'h2,
		ACR_REG = 4'h3,
		ACR_REG_ACK = 4'h4,
		ACR_WR = 4'h5,
		ACR_WR_ACK = 4'h6,
		ACR_RD = 4'h7,
		ACR_RD_ACK = 4'h8,
		ACR_WAIT = 4'h9
	} acr_i2c_st_t;

	typedef enum logic [2:0] {
		ACR_PW_OFF = 3'h0,
		ACR_PW_LV_UP = 3'h1,
		ACR_PW_SLEEP = 3'h2,
		ACR_PW_PS_UP = 3'h3,
		ACR_PW_RUN = 3'h4
	} acr_pwr_st_t;

	typedef struct packed {
		logic power_stage_en;
		logic digital_domain_on;
		logic lv_standby;
		logic playback_ready;
	} acr_pwr_out_t;

	typedef struct packed {
		logic [7:0] digital_path_control;
		logic [7:0] volume_configuration;
		logic [7:0] left_volume;
		logic [7:0] right_volume;
		logic [7:0] analog_control;
		logic [7:0] fault_config;
	} acr_audio_cfg_t;

endpackage : acr_pkg

// ==== core/acr_power_seq.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Power domain sequencer
// ****************************************************************
module acr_power_seq
	import acr_pkg::*;
#(
	parameter int SLEEP_WAKE = SLEEP_WAKE_CYC,
	parameter int SHUT_WAKE = SHUTDOWN_WAKE_CYC,
	parameter int CW = 12
)
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic amp_sleep_request_i,
	input wire logic amp_shutdown_n_i,
	output acr_pwr_out_t pwr_o
);

	typedef struct packed {
		acr_pwr_st_t st;
		logic [CW-1:0] cnt;
		acr_pwr_out_t out;
	} acr_seq_st_t;

	acr_seq_st_t q;
	acr_seq_st_t next_q;

	always_comb
	begin
		next_q = q;
		case (q.st)
			ACR_PW_OFF:
			begin
				// Full restart pays the long low-voltage ramp
				if (amp_shutdown_n_i)
				begin
					next_q.st = ACR_PW_LV_UP;
					next_q.cnt = CW'(SHUT_WAKE - 1);
				end
			end
			ACR_PW_LV_UP:
			begin
				if (!amp_shutdown_n_i)
					next_q.st = ACR_PW_OFF;
				else if (q.cnt != '0)
					next_q.cnt = q.cnt - CW'(1);
				else if (amp_sleep_request_i)
					next_q.st = ACR_PW_SLEEP;
				else
				begin
					next_q.st = ACR_PW_PS_UP;
					next_q.cnt = CW'(SLEEP_WAKE - 1);
				end
			end
			ACR_PW_SLEEP:
			begin
				if (!amp_shutdown_n_i)
					next_q.st = ACR_PW_OFF;
				else if (!amp_sleep_request_i)
				begin
					// Standby skips the long ramp
					next_q.st = ACR_PW_PS_UP;
					next_q.cnt = CW'(SLEEP_WAKE - 1);
				end
			end
			ACR_PW_PS_UP:
			begin
				if (!amp_shutdown_n_i)
					next_q.st = ACR_PW_OFF;
				else if (amp_sleep_request_i)
					next_q.st = ACR_PW_SLEEP;
				else if (q.cnt == '0)
					next_q.st = ACR_PW_RUN;
				else
					next_q.cnt = q.cnt - CW'(1);
			end
			ACR_PW_RUN:
			begin
				if (!amp_shutdown_n_i)
					next_q.st = ACR_PW_OFF;
				else if (amp_sleep_request_i)
					next_q.st = ACR_PW_SLEEP;
			end
			default:
				next_q.st = ACR_PW_OFF;
		endcase
		next_q.out.digital_domain_on = next_q.st != ACR_PW_OFF;
		next_q.out.lv_standby = next_q.st == ACR_PW_SLEEP;
		next_q.out.power_stage_en = next_q.st == ACR_PW_PS_UP ||
			next_q.st == ACR_PW_RUN;
		next_q.out.playback_ready = next_q.st == ACR_PW_RUN;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			q <= '{st: ACR_PW_OFF, cnt: '0, out: '0};
		else
			q <= next_q;
	end

	assign pwr_o = q.out;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence leave_sleep;
		q.st == ACR_PW_SLEEP && amp_shutdown_n_i && !amp_sleep_request_i;
	endsequence

	sequence leave_off;
		q.st == ACR_PW_OFF && amp_shutdown_n_i;
	endsequence

	sleep_stage_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		amp_sleep_request_i && amp_shutdown_n_i |=>
		!pwr_o.power_stage_en && !pwr_o.playback_ready)
		else $error("power stage on while sleep requested");

	shutdown_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!amp_shutdown_n_i |=>
		!pwr_o.digital_domain_on && !pwr_o.power_stage_en)
		else $error("domains still up in shutdown");

	wake_fast_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		leave_sleep |=> q.st == ACR_PW_PS_UP &&
		q.cnt == CW'(SLEEP_WAKE - 1) && pwr_o.digital_domain_on)
		else $error("sleep exit did not take the short ramp");

	wake_slow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		leave_off |=> q.st == ACR_PW_LV_UP &&
		q.cnt == CW'(SHUT_WAKE - 1) && !pwr_o.power_stage_en)
		else $error("shutdown exit did not take the long ramp");

endmodule : acr_power_seq

// ==== verification/acr_i2c_master.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Host side serial bus master model
// ****************************************************************
module acr_i2c_master
(
	input wire logic core_clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// One third of a bit time in core cycles, varied by the bench
	int hp = 3;

	initial
	begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end

	task automatic tick();
		repeat (hp) @(posedge core_clk_i);
		#1;
	endtask : tick

	// Also serves as repeated start, entered with scl low
	task automatic start();
		sda_oe_o = 1'b0;
		tick();
		scl_o = 1'b1;
		tick();
		sda_oe_o = 1'b1;
		tick();
		scl_o = 1'b0;
		tick();
	endtask : start

	task automatic stop();
		sda_oe_o = 1'b1;
		tick();
		scl_o = 1'b1;
		tick();
		sda_oe_o = 1'b0;
		tick();
	endtask : stop

	// Data only moves while scl is low
	task automatic bit_xfer(input logic b, output logic got);
		sda_oe_o = ~b;
		tick();
		scl_o = 1'b1;
		tick();
		got = sda_i;
		scl_o = 1'b0;
		tick();
	endtask : bit_xfer

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], g);
		bit_xfer(1'b1, g);
		ack = ~g;
	endtask : send_byte

	// Ack bit is low to ask for more, high on the last byte
	task automatic recv_byte(output logic [7:0] d, input logic nack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_xfer(1'b1, d[i]);
		bit_xfer(nack, g);
	endtask : recv_byte

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] r,
		input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({dev, 1'b0}, a0);
		send_byte(r, a1);
		send_byte(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : write_reg

	task automatic read_reg(input logic [6:0] dev, input logic [7:0] r,
		output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({dev, 1'b0}, a0);
		send_byte(r, a1);
		start();
		send_byte({dev, 1'b1}, a2);
		recv_byte(d, 1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask : read_reg

	task automatic write_two(input logic [6:0] dev, input logic [7:0] r,
		input logic [7:0] d0, input logic [7:0] d1, output logic ok);
		logic a0, a1, a2, a3;
		start();
		send_byte({dev, 1'b0}, a0);
		send_byte(r, a1);
		send_byte(d0, a2);
		send_byte(d1, a3);
		stop();
		ok = a0 & a1 & a2 & a3;
	endtask : write_two

	task automatic read_two(input logic [6:0] dev, input logic [7:0] r,
		output logic [15:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({dev, 1'b0}, a0);
		send_byte(r, a1);
		start();
		send_byte({dev, 1'b1}, a2);
		recv_byte(d[15:8], 1'b0);
		recv_byte(d[7:0], 1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask : read_two
endmodule : acr_i2c_master

// ==== verification/tb_amp_control_register_bank.sv ====
`timescale 1ns/1ps
module tb_amp_control_register_bank
	import acr_pkg::*;
;
	localparam logic [7:0] ID = 8'h5A; // Arbitrary value
	localparam int SLW = 4;
	localparam int SHW = 12;
	localparam logic [6:0] DEV = {DEV_ADDR_BASE, 1'b1};
	logic clk, rst, scl, sda, d_o, d_oe, m_oe, pin, slp, sdn, p_sl, p_sd;
	logic [2:0] fault;
	logic [19:0] clip;
	acr_audio_cfg_t acfg;
	acr_pwr_out_t pwr;
	logic [7:0] mir [0:17];
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int wake_cnt = 0;

	// Open drain wire with pull-up
	assign sda = ~((d_oe & ~d_o) | m_oe);

	acr_top #(.DEVICE_ID(ID), .SLEEP_WAKE(SLW), .SHUT_WAKE(SHW)) dut (
		.core_clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
		.sda_o(d_o), .sda_oe_o(d_oe), .sleep_or_addr_select_pin_i(pin),
		.fault_status_i(fault), .clip_threshold_level_o(clip),
		.amp_sleep_request_o(slp), .amp_shutdown_n_o(sdn),
		.audio_cfg_o(acfg), .pwr_o(pwr));

	acr_i2c_master m (.core_clk_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_oe_o(m_oe));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Cycles from the last power bit change until playback is ready
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (slp !== p_sl || sdn !== p_sd)
			wake_cnt <= 0;
		else if (pwr.playback_ready !== 1'b1)
			wake_cnt <= wake_cnt + 1;
		p_sl <= slp;
		p_sd <= sdn;
		if (cyc == 90000)
		begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end

	// ************************************************************
	// Checking helpers
	// ************************************************************
	task automatic stop_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got,
				exp);
		end
	endtask : check

	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			REG_PWR, REG_LVOL, REG_RVOL, REG_CLIP_MID: return WM_FULL;
			REG_DIG: return WM_DIG;
			REG_VOL_CFG: return WM_VOL_CFG;
			REG_ANA: return WM_ANA;
			REG_FAULT: return WM_FAULT;
			REG_CLIP_LOW: return WM_CLIP_LOW;
			default: return 8'h00;
		endcase
	endfunction : wmask

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		logic [7:0] v;
		v = (a < 8'h12) ? mir[a] : 8'h00;
		if (a == REG_FAULT)
			v = v | {5'h00, fault};
		return v;
	endfunction : exp_rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		m.hp = 3 + int'($urandom_range(3));
		m.write_reg(DEV, a, d, ok);
		check({31'h0, ok}, 32'h1);
		if (a < 8'h12)
			mir[a] = (mir[a] & ~wmask(a)) | (d & wmask(a));
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		logic [7:0] d;
		logic ok;
		m.hp = 3 + int'($urandom_range(3));
		m.read_reg(DEV, a, d, ok);
		check({31'h0, ok}, 32'h1);
		check({24'h0, d}, {24'h0, exp_rd(a)});
	endtask : rd_chk

	task automatic out_chk();
		check({12'h0, clip}, {12'h0, mir[1][7:2], mir[16], mir[17][7:2]});
		check({30'h0, slp, sdn}, {30'h0, mir[1][1:0]});
		check(acfg[47:16], {mir[2], mir[3], mir[4], mir[5]});
		check({16'h0, acfg[15:0]}, {16'h0, mir[6], mir[8]});
	endtask : out_chk

	task automatic wait_ready(output int t);
		for (int k = 0; k < 500 && pwr.playback_ready !== 1'b1; k++)
			@(posedge clk);
		#1;
		t = wake_cnt;
		check({31'h0, pwr.playback_ready}, 32'h1);
	endtask : wait_ready

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [7:0] a8;
		logic [15:0] d16;
		logic ok;
		int t_sl;
		int t_sd;
		rst = 1'b1;
		pin = 1'b1;
		fault = 3'h0;
		void'($urandom(32'hd51c));
		mir = '{default: 8'h00};
		mir[0] = ID;
		mir[1] = RST_PWR;
		mir[2] = RST_DIG;
		mir[3] = RST_VOL_CFG;
		mir[4] = RST_VOL;
		mir[5] = RST_VOL;
		mir[6] = RST_ANA;
		mir[8] = RST_FAULT;
		mir[16] = RST_CLIP_MID;
		mir[17] = RST_CLIP_LOW;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		// Pin returns to sleep duty once the address is caught
		#1 pin = 1'b0;
		out_chk();
		for (int a = 0; a < 18; a++)
			rd_chk(8'(a));
		for (int i = 0; i < 30; i++)
		begin
			a8 = (i < 18) ? 8'(i) : 8'($urandom_range(17));
			fault = 3'($urandom);
			wr(a8, 8'($urandom));
			out_chk();
			rd_chk(a8);
		end
		wr(8'h20, 8'hA5);
		rd_chk(8'h20);
		m.write_reg({DEV_ADDR_BASE, 1'b0}, REG_LVOL, ~mir[4], ok);
		check({31'h0, ok}, 32'h0);
		rd_chk(REG_LVOL);
		// Burst write and acked burst read walk the pointer
		a8 = 8'($urandom);
		m.write_two(DEV, REG_LVOL, a8, ~a8, ok);
		check({31'h0, ok}, 32'h1);
		mir[4] = a8;
		mir[5] = ~a8;
		m.read_two(DEV, REG_LVOL, d16, ok);
		check({31'h0, ok}, 32'h1);
		check({16'h0, d16}, {16'h0, a8, ~a8});
		out_chk();
		wr(REG_PWR, {mir[1][7:2], 2'b00});
		repeat (3) @(posedge clk);
		#1;
		check({30'h0, pwr.digital_domain_on, pwr.power_stage_en}, 32'h0);
		wr(REG_PWR, {mir[1][7:2], 2'b01});
		wait_ready(t_sd);
		wr(REG_PWR, {mir[1][7:2], 2'b11});
		repeat (3) @(posedge clk);
		#1;
		check({30'h0, pwr.lv_standby, pwr.power_stage_en}, 32'h2);
		wr(REG_PWR, {mir[1][7:2], 2'b01});
		wait_ready(t_sl);
		check({31'h0, t_sl < t_sd}, 32'h1);
		out_chk();
		stop_test();
	end
endmodule : tb_amp_control_register_bank
